// [rtl/sdgc_pkg.sv]
/*
 * package for the serial-command configuration register set:
 * command codes, frame layout, field widths, reset values.
 * assumes a 24-bit frame, msb first, bit 23 = read flag.
 */
package sdgc_pkg;
	localparam int          FRAME_BITS     = 24;
	localparam int          RW_BIT         = 23;
	localparam int          CMD_HI         = 22;
	localparam int          CMD_LO         = 16;
	localparam int          DAC_CNT        = 4;
	localparam int          CODE_W         = 10;
	localparam int          CODE_LO        = 2;
	localparam int          GPIO_W         = 12;
	localparam logic [6:0]  CMD_IDLE       = 7'h00;
	localparam logic [6:0]  CMD_DAC_EN     = 7'h18;
	localparam logic [6:0]  CMD_DAC_BCAST  = 7'h19;
	localparam logic [6:0]  CMD_READY_CTL  = 7'h1e;
	localparam logic [6:0]  CMD_PIN_DIR    = 7'h1f;
	localparam logic [6:0]  CMD_PWR_READY  = 7'h20;
	localparam logic [6:0]  CMD_PIN_IN     = 7'h30;
	localparam logic [6:0]  CMD_PIN_OUT    = 7'h31;
	localparam logic [3:0]  DAC_EN_RST     = 4'h0;
	localparam logic        READY_CTL_RST  = 1'b0;
	localparam logic [11:0] PIN_DIR_RST    = 12'h000;
	localparam logic [11:0] PIN_OUT_RST    = 12'h000;
	localparam logic [9:0]  DAC_CODE_RST   = 10'h000;
endpackage : sdgc_pkg

// [rtl/sdgc_regs.sv]
/*
 * serial register bank: shifts 24-bit command frames in on the rising serial
 * clock edges, applies them at frame end, returns the answer next frame.
 * assumes serial clock, select and data arrive asynchronous to i_mclk,
 * serial clock at most a fraction of i_mclk (bench: 400 ns or 800 ns vs 50 ns).
 */
`timescale 1ns/1ps
module sdgc_regs
	import sdgc_pkg::*;
(
	input  wire logic                      i_mclk,
	input  wire logic                      i_rstn,
	input  wire logic                      i_sclk,
	input  wire logic                      i_chip_select_low,
	input  wire logic                      i_sdi,
	output logic                           o_sdo,
	output logic                           o_sdo_oe,
	input  wire logic                      i_powerup_done,
	input  wire logic                      i_conv_data_fresh,
	output logic                           o_data_ready_pin,
	input  wire logic [GPIO_W-1:0]         i_gpio,
	output logic      [GPIO_W-1:0]         o_gpio,
	output logic      [GPIO_W-1:0]         o_gpio_oe,
	output logic      [DAC_CNT-1:0]        o_dac_enable_mask,
	output logic      [DAC_CNT*CODE_W-1:0] o_dac_code,
	output logic      [DAC_CNT-1:0]        o_dac_load
);

	// ***************************************************************
	// input synchronisers
	// ***************************************************************
	logic [2:0]        sclk_q;
	logic [1:0]        csn_q;
	logic [1:0]        sdi_q;
	logic [1:0]        pwr_q;
	logic [1:0]        fresh_q;
	logic [GPIO_W-1:0] gpi_m_q;
	logic [GPIO_W-1:0] gpi_q;

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			sclk_q  <= 3'h0;
			csn_q   <= 2'h3;
			sdi_q   <= 2'h0;
			pwr_q   <= 2'h0;
			fresh_q <= 2'h0;
			gpi_m_q <= '0;
			gpi_q   <= '0;
		end else begin
			sclk_q  <= {sclk_q[1:0], i_sclk};
			csn_q   <= {csn_q[0], i_chip_select_low};
			sdi_q   <= {sdi_q[0], i_sdi};
			pwr_q   <= {pwr_q[0], i_powerup_done};
			fresh_q <= {fresh_q[0], i_conv_data_fresh};
			gpi_m_q <= i_gpio;
			gpi_q   <= gpi_m_q;
		end
	end

	// edges are found on the synchronised copy, so a serial half period
	// must span at least one system clock or an edge is lost
	logic sel;
	logic rise;
	logic fall;
	assign sel  = ~csn_q[1];
	assign rise = sel & sclk_q[1] & ~sclk_q[2];
	assign fall = sel & ~sclk_q[1] & sclk_q[2];

	// ***************************************************************
	// frame shifter and register file
	// ***************************************************************
	logic [FRAME_BITS-1:0]   rx_q, rx_d;
	logic [FRAME_BITS-1:0]   tx_q, tx_d;
	logic [FRAME_BITS-1:0]   ans_q, ans_d;
	logic [4:0]              cnt_q, cnt_d;
	logic                    act_q, act_d;
	logic [DAC_CNT-1:0]      den_q, den_d;
	logic                    rpc_q, rpc_d;
	logic [GPIO_W-1:0]       dir_q, dir_d;
	logic [GPIO_W-1:0]       gpo_q, gpo_d;
	logic [CODE_W-1:0]       code_q, code_d;
	logic [DAC_CNT-1:0]      load_q, load_d;
	logic                    sdo_q, sdo_d;
	logic [FRAME_BITS-1:0]   fr;
	logic [6:0]              cmd;
	logic                    rd;
	logic [15:0]             pay;

	// a frame cut short never reaches its 24th rise, so it changes nothing
	always_comb begin
		rx_d   = rx_q;
		tx_d   = tx_q;
		ans_d  = ans_q;
		cnt_d  = cnt_q;
		act_d  = act_q;
		den_d  = den_q;
		rpc_d  = rpc_q;
		dir_d  = dir_q;
		gpo_d  = gpo_q;
		code_d = code_q;
		load_d = '0;
		sdo_d  = sdo_q;
		fr     = {rx_q[FRAME_BITS-2:0], sdi_q[1]};
		cmd    = fr[CMD_HI:CMD_LO];
		rd     = fr[RW_BIT];
		pay    = 16'h0000;
		if (!sel) begin
			cnt_d = 5'h00;
			act_d = 1'b0;
		end else if (!act_q) begin
			// answer of the previous frame goes out from select fall
			act_d = 1'b1;
			tx_d  = ans_q;
			sdo_d = ans_q[FRAME_BITS-1];
		end else if (rise) begin
			// data is sampled on rising serial clock
			rx_d  = fr;
			cnt_d = cnt_q + 5'h01;
			if (cnt_q == 5'(FRAME_BITS - 1)) begin
				case (cmd)
					CMD_DAC_EN: begin
						if (rd) pay = {12'h000, den_q};
						else den_d = fr[DAC_CNT-1:0];
					end
					CMD_DAC_BCAST: begin
						if (!rd) begin
							code_d = fr[CODE_LO+CODE_W-1:CODE_LO];
							load_d = '1;
						end
					end
					CMD_READY_CTL: begin
						if (rd) pay = {15'h0000, rpc_q};
						else rpc_d = fr[0];
					end
					CMD_PIN_DIR: begin
						if (rd) pay = {4'h0, dir_q};
						else dir_d = fr[GPIO_W-1:0];
					end
					CMD_PWR_READY: begin
						if (rd) pay = {15'h0000, pwr_q[1]};
					end
					CMD_PIN_IN: begin
						if (rd) pay = {4'h0, gpi_q};
					end
					CMD_PIN_OUT: begin
						if (rd) pay = {4'h0, gpo_q};
						else gpo_d = fr[GPIO_W-1:0];
					end
					CMD_IDLE: pay = 16'h0000;
					default: pay = 16'h0000;
				endcase
				// the answer waits here until the next select fall
				ans_d = (cmd == CMD_IDLE) ? '0 : {rd, cmd, pay};
			end
		end else if (fall) begin
			// shift the answer out on falling serial clock
			tx_d  = {tx_q[FRAME_BITS-2:0], 1'b0};
			sdo_d = tx_q[FRAME_BITS-2];
		end
	end

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			rx_q   <= '0;
			tx_q   <= '0;
			ans_q  <= '0;
			cnt_q  <= 5'h00;
			act_q  <= 1'b0;
			den_q  <= DAC_EN_RST;
			rpc_q  <= READY_CTL_RST;
			dir_q  <= PIN_DIR_RST;
			gpo_q  <= PIN_OUT_RST;
			code_q <= DAC_CODE_RST;
			load_q <= '0;
			sdo_q  <= 1'b0;
		end else begin
			rx_q   <= rx_d;
			tx_q   <= tx_d;
			ans_q  <= ans_d;
			cnt_q  <= cnt_d;
			act_q  <= act_d;
			den_q  <= den_d;
			rpc_q  <= rpc_d;
			dir_q  <= dir_d;
			gpo_q  <= gpo_d;
			code_q <= code_d;
			load_q <= load_d;
			sdo_q  <= sdo_d;
		end
	end

	// ***************************************************************
	// outputs
	// ***************************************************************
	assign o_sdo             = sdo_q;
	assign o_sdo_oe          = sel;
	assign o_gpio            = gpo_q & dir_q;
	assign o_gpio_oe         = dir_q;
	assign o_dac_enable_mask = den_q;
	// one code register feeds every lane, so the dacs can never disagree
	assign o_dac_code        = {DAC_CNT{code_q}};
	assign o_dac_load        = load_q;
	// active-low pin, held high while disabled
	// control bit high forces the pin to its inactive level
	assign o_data_ready_pin  = rpc_q | ~fresh_q[1];

endmodule : sdgc_regs

// [tb/sdgc_host.sv]
/* host model: spi master sending one 24-bit word per call, msb first.
 * assumes the device samples at sclk rise and shifts out after sclk fall */
`timescale 1ns/1ps
module sdgc_host (
	output logic		o_sclk,
	output logic		o_chip_select_low,
	output logic		o_sdi,
	input  wire logic	i_sdo
);
	initial begin
		o_sclk = 1'b0;
		o_chip_select_low = 1'b1;
		o_sdi = 1'b0;
	end
	// sclk rests low between frames; hp is the half period in ns
	// calls start on an i_mclk rise and hp is a whole number of periods,
	// so every change is non-blocking to stay clear of the device's sampling
	task automatic xfer(input logic [23:0] f, input int hp, output logic [23:0] r);
		o_chip_select_low <= 1'b0;
		for (int i = 23; i >= 0; i--) begin
			o_sdi <= f[i];
			#hp o_sclk <= 1'b1;
			r[i] = i_sdo;
			#hp o_sclk <= 1'b0;
		end
		#hp o_chip_select_low <= 1'b1;
		o_sdi <= ~o_sdi;
		#(2 * hp);
	endtask : xfer
endmodule : sdgc_host

// [tb/sdgc_properties.sv]
/* checker on the register bank ports.
 * assumes a bind onto sdgc_regs and a host that keeps select high between frames */
`timescale 1ns/1ps
module sdgc_properties (
	input wire logic	i_mclk,
	input wire logic	i_rstn,
	input wire logic	i_chip_select_low,
	input wire logic	i_conv_data_fresh,
	input wire logic	o_sdo_oe,
	input wire logic	o_data_ready_pin,
	input wire logic [11:0]	o_gpio,
	input wire logic [11:0]	o_gpio_oe,
	input wire logic [39:0]	o_dac_code,
	input wire logic [3:0]	o_dac_load
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_rstn);
	sequence s_idle; i_chip_select_low [*5]; endsequence
	sequence s_stale; !i_conv_data_fresh [*5]; endsequence
	AST_GPIO_MASK: assert property ((o_gpio & ~o_gpio_oe) == 12'h000)
		else $error("gpio drives an input pin");
	AST_LOAD_ALL: assert property (|o_dac_load |-> o_dac_load == 4'hf)
		else $error("partial dac load");
	AST_LOAD_ONCE: assert property (|o_dac_load |=> o_dac_load == 4'h0)
		else $error("dac load longer than one cycle");
	AST_LANES: assert property (o_dac_code == {4{o_dac_code[9:0]}})
		else $error("dac lanes differ");
	AST_LOAD_FRAME: assert property (|o_dac_load |-> $past(i_chip_select_low, 2) == 1'b0)
		else $error("dac load outside a frame");
	AST_OE_IDLE: assert property (s_idle |-> !o_sdo_oe)
		else $error("sdo driven while deselected");
	AST_OE_ON: assert property ($fell(i_chip_select_low) |-> ##[1:5] o_sdo_oe)
		else $error("sdo not driven in frame");
	AST_READY_OFF: assert property (s_stale |-> o_data_ready_pin)
		else $error("data ready without fresh data");
endmodule : sdgc_properties

// [tb/tb_top.sv]
/* bench: table of frames through the host model, then broadcast, reset and
 * data-ready cases. assumes sdgc_host as the spi master */
`timescale 1ns/1ps
module tb_top;
	logic		i_mclk = 1'b0, i_rstn = 1'b0, i_powerup_done = 1'b0;
	logic		i_conv_data_fresh = 1'b1;
	logic [11:0]	i_gpio = 12'ha5c;
	logic		i_sclk, i_chip_select_low, i_sdi, o_sdo, o_sdo_oe, o_data_ready_pin;
	logic [11:0]	o_gpio, o_gpio_oe;
	logic [3:0]	o_dac_enable_mask, o_dac_load;
	logic [39:0]	o_dac_code;
	logic [23:0]	r;
	int		err_count = 0, n_compared = 0, n_load = 0, cyc = 0;
	logic [47:0]	rows [13] = '{
		48'h180005_180000,
		48'h98ffff_980005,
		48'h1f0ff0_1f0000,
		48'h9f0000_9f0ff0,
		48'h310abc_310000,
		48'hb10000_b10abc,
		48'h1e0001_1e0000,
		48'h9e0000_9e0001,
		48'ha00000_a00001,
		48'hb00000_b00a5c,
		48'h55ffff_550000,
		48'h990000_990000,
		48'h000000_000000
	};
	always #25 i_mclk = ~i_mclk;
	always @(posedge i_mclk) begin
		cyc <= cyc + 1;
		n_load <= n_load + int'(o_dac_load === 4'hf);
		if (cyc == 20000) begin
			err_count++;
			final_report();
		end
	end
	// a released data line shows the inverse of its last bit
	sdgc_host i_host (.o_sclk(i_sclk), .o_chip_select_low(i_chip_select_low),
		.o_sdi(i_sdi), .i_sdo(o_sdo_oe ? o_sdo : ~o_sdo));
	sdgc_regs i_dut (.i_mclk, .i_rstn, .i_sclk, .i_chip_select_low, .i_sdi, .o_sdo, .o_sdo_oe,
		.i_powerup_done, .i_conv_data_fresh, .o_data_ready_pin, .i_gpio, .o_gpio,
		.o_gpio_oe, .o_dac_enable_mask, .o_dac_code, .o_dac_load);
	task automatic chk(input logic [39:0] e, input logic [39:0] g, input string nm);
		n_compared++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task automatic xf(input logic [23:0] f, input logic [23:0] e, input int hp);
		i_host.xfer(f, hp, r);
		chk(40'(e), 40'(r), "answer");
	endtask : xf
	task automatic final_report();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : final_report
	initial begin
		repeat (2) @(posedge i_mclk);
		i_rstn <= 1'b1;
		i_powerup_done <= 1'b1;
		repeat (4) @(posedge i_mclk);
		i_host.xfer(rows[0][47:24], 200, r);
		for (int i = 1; i < 13; i++)
			xf(rows[i][47:24], rows[i - 1][23:0], (i == 6) ? 400 : 200);
		chk(40'hff0ab0, 40'({o_gpio_oe, o_gpio}), "pins");
		chk(40'h5, 40'(o_dac_enable_mask), "mask");
		chk(40'h1, 40'(o_data_ready_pin), "ready pin");
		$display("table done");
		xf(24'h190aa8, 24'h000000, 200);
		xf(24'h000000, 24'h190000, 200);
		chk({4{10'h2aa}}, o_dac_code, "code");
		chk(40'h1, 40'(n_load), "loads");
		$display("broadcast done");
		i_rstn <= 1'b0;
		i_powerup_done <= 1'b0;
		repeat (2) @(posedge i_mclk);
		i_rstn <= 1'b1;
		repeat (4) @(posedge i_mclk);
		chk(40'h0, 40'({o_dac_enable_mask, o_gpio_oe, o_gpio}), "regs");
		chk(40'h0, 40'(o_data_ready_pin), "ready pin");
		i_conv_data_fresh <= 1'b0;
		repeat (6) @(posedge i_mclk);
		chk(40'h1, 40'(o_data_ready_pin), "ready pin");
		i_host.xfer(24'ha00000, 200, r);
		xf(24'h9f0000, 24'ha00000, 200);
		xf(24'h000000, 24'h9f0000, 200);
		$display("reset done");
		final_report();
	end
endmodule : tb_top
bind sdgc_regs sdgc_properties i_props (.i_mclk, .i_rstn, .i_chip_select_low,
	.i_conv_data_fresh, .o_sdo_oe, .o_data_ready_pin, .o_gpio, .o_gpio_oe, .o_dac_code,
	.o_dac_load);
